// ### pcsc_map.svh
// register offsets, field positions, codes and timing figures of the coding and alignment block
`ifndef PCSC_MAP_SVH
`define PCSC_MAP_SVH
`define PCSC_REG_CTRL 4'h0
`define PCSC_REG_SEED 4'h4
`define PCSC_REG_STAT 4'h8
`define PCSC_REG_ERRS 4'hc
`define PCSC_CTRL_SCR_EN 0
`define PCSC_CTRL_SCR_SYNC 1
`define PCSC_CTRL_IL67 2
`define PCSC_CTRL_TX_POL 3
`define PCSC_CTRL_RX_POL 4
`define PCSC_CTRL_TX_SLIP 5
`define PCSC_CTRL_RX_SLIP 6
`define PCSC_CTRL_DISP_EN 7
`define PCSC_CTRL_RESET 8'h01
`define PCSC_SEED_RESET 15'h0001
`define PCSC_SEED_HI 43'h2aaaaaaaaaa
`define PCSC_HDR_DATA 2'h2
`define PCSC_HDR_CTRL 2'h1
`define PCSC_BT_IDLE 8'h1e
`define PCSC_BT_START 8'h78
`define PCSC_CH_IDLE 8'h07
`define PCSC_CH_START 8'hfb
`define PCSC_CH_TERM 8'hfd
`define PCSC_CH_ERR 8'hfe
`define PCSC_E_CODE 7'h1e
`define PCSC_W66 7'd66
`define PCSC_W67 7'd67
`define PCSC_FLAG_BIT 66
`define PCSC_SCR_TAP_A 38
`define PCSC_SCR_TAP_B 57
`define PCSC_LOCK_HDRS 7'd64
`define PCSC_WIN_HDRS 7'd64
`define PCSC_BAD_LOSE 5'd16
`define PCSC_BER_LIMIT 5'd16
`define PCSC_BER_WINDOW_MS 125
`define PCSC_CLK_KHZ 40000
`endif

// ### pcsc_pkg.sv
// types shared by the coding and alignment block
package pcsc_pkg;
  typedef enum logic {SYNC_SEARCH, SYNC_LOCKED} pcsc_sync_t;
  typedef enum logic {SEQ_IDLE, SEQ_PKT} pcsc_seq_t;
  typedef enum logic [2:0] {BLK_C, BLK_S, BLK_D, BLK_T, BLK_E} pcsc_blk_t;
endpackage

// ### pcsc_top.sv
// 64b/66b coding, scrambling, disparity, block sync and gearbox of one lane
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pcsc_map.svh"

// Contract
// [R1] encoder turns 64 data bits and 8 control bits into a 66-bit block
// [R2] transmit sequencer checks each word and enforces legal block-type order
// [R3] decoder turns descrambled blocks back into 64 data and 8 control bits
// [R4] receive sequencer replaces output with error blocks while high error rate
// [R5] scrambler uses x^58+x^39+1 when enabled
// [R6] synchronous scrambler mode, used for the 67-bit lane format
// [R7] self-synchronizing scrambler mode, used for the 66-bit format
// [R8] descrambler uses the same polynomial as the transmitter
// [R9] software gives each lane its own 15-bit seed for synchronous mode
// [R10] disparity generator keeps running disparity within plus or minus 96
// [R11] bit 66 of each word flags an inverted payload
// [R12] checker inverts payload bits 63:0 when the flag is set
// [R13] block sync finds 66-bit or 67-bit word boundaries
// [R14] search slips one bit per bad two-bit header
// [R15] lock asserted after a fixed count of good headers
// [R16] header error pulses per bad header, only while locked
// [R17] gearbox adapts serializer width to coded word width
// [R18] transmit polarity inversion flips every sent bit
// [R19] receive polarity inversion flips every received bit
// [R20] transmit slip mode shifts one bit per rising slip edge
// [R21] receive slip mode stops search, slips one bit per rising edge
// [R22] high error flag when over 16 bad headers in 125 ms
// [R23] slip edges detected on this clock, count wraps after width minus one
// [R24] too many bad headers drop lock and restart search
module pcsc_top import pcsc_pkg::*; #(
  parameter int PMA_W = 40,
  parameter int BER_WINDOW_CYC = `PCSC_BER_WINDOW_MS * `PCSC_CLK_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // transmit words from the framing side
  input wire logic [63:0] txData,
  input wire logic [7:0] txCtrl,
  input wire logic txValid,
  output logic txReady,
  output logic txSequenceError,
  // serializer side
  output logic [PMA_W-1:0] pmaTxData,
  output logic pmaTxValid,
  input wire logic [PMA_W-1:0] pmaRxData,
  input wire logic pmaRxValid,
  // receive words to the framing side
  output logic [63:0] rxData,
  output logic [7:0] rxCtrl,
  output logic rxValid,
  // slip inputs and status
  input wire logic transmitSlipPulse,
  input wire logic receiveSlipPulse,
  output logic blockAlignmentLocked,
  output logic syncHeaderErrorFlag,
  output logic highErrorRateFlag,
  output logic descramblerErrorFlag
);
  localparam int AW = 192;

  function automatic logic [7:0] termType(input int k);
    case (k)
      0: termType = 8'h87;
      1: termType = 8'h99;
      2: termType = 8'haa;
      3: termType = 8'hb4;
      4: termType = 8'hcc;
      5: termType = 8'hd2;
      6: termType = 8'he1;
      default: termType = 8'hff;
    endcase
  endfunction

  function automatic int termLane(input logic [7:0] t);
    termLane = 8;
    for (int k = 0; k < 8; k++) begin
      if (t == termType(k)) begin
        termLane = k;
      end
    end
  endfunction

  // one pass over 64 bits; state returned above the data
  function automatic logic [121:0] scram(input logic [63:0] d, input logic [57:0] s0,
                                         input logic selfSync, input logic descr);
    logic [57:0] s;
    logic [63:0] o;
    logic fb;
    s = s0;
    o = '0;
    for (int i = 0; i < 64; i++) begin
      fb = s[`PCSC_SCR_TAP_A] ^ s[`PCSC_SCR_TAP_B];
      o[i] = d[i] ^ fb;
      s = {s[56:0], selfSync ? (descr ? d[i] : o[i]) : fb};
    end
    scram = {s, o};
  endfunction

  // configuration
  logic [7:0] ctrl_r;
  logic [14:0] seed_r;
  logic seedLoad_r;
  logic scrEn, scrSync, il67, txPol, rxPol, txSlipMode, rxSlipMode, dispOn;
  logic [6:0] cw;
  logic [66:0] cwMask;
  logic [57:0] seedState;
  assign scrEn = ctrl_r[`PCSC_CTRL_SCR_EN];
  assign scrSync = ctrl_r[`PCSC_CTRL_SCR_SYNC];
  assign il67 = ctrl_r[`PCSC_CTRL_IL67];
  assign txPol = ctrl_r[`PCSC_CTRL_TX_POL];
  assign rxPol = ctrl_r[`PCSC_CTRL_RX_POL];
  assign txSlipMode = ctrl_r[`PCSC_CTRL_TX_SLIP];
  assign rxSlipMode = ctrl_r[`PCSC_CTRL_RX_SLIP];
  assign dispOn = il67 & ctrl_r[`PCSC_CTRL_DISP_EN];
  assign cw = il67 ? `PCSC_W67 : `PCSC_W66; // see [R13]
  assign cwMask = il67 ? {67{1'b1}} : {1'b0, {66{1'b1}}};
  assign seedState = {`PCSC_SEED_HI, seed_r}; // see [R9]

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `PCSC_CTRL_RESET;
      seed_r <= `PCSC_SEED_RESET;
      seedLoad_r <= 1'b0;
    end else begin
      seedLoad_r <= 1'b0;
      if (regWrite) begin
        if (regAddr == `PCSC_REG_CTRL) begin
          ctrl_r <= regWrData[7:0];
        end else if (regAddr == `PCSC_REG_SEED) begin
          seed_r <= regWrData[14:0];
          seedLoad_r <= 1'b1;
        end
      end
    end
  end

  // transmit encoder and sequencer
  logic [1:0] encHdr;
  logic [63:0] encPay, lowBytes;
  pcsc_blk_t encCls;
  pcsc_seq_t txSeq_r, txSeqNxt;
  logic txSeqBad, txFire;
  assign txFire = txValid & txReady;

  always_comb begin
    encHdr = `PCSC_HDR_CTRL;
    encPay = {{8{`PCSC_E_CODE}}, `PCSC_BT_IDLE};
    encCls = BLK_E;
    lowBytes = '0;
    if (txCtrl == 8'h00) begin // see [R1]
      encHdr = `PCSC_HDR_DATA;
      encPay = txData;
      encCls = BLK_D;
    end else if (txCtrl == 8'hff && txData == {8{`PCSC_CH_IDLE}}) begin
      encPay = {56'h0, `PCSC_BT_IDLE};
      encCls = BLK_C;
    end else if (txCtrl == 8'h01 && txData[7:0] == `PCSC_CH_START) begin
      encPay = {txData[63:8], `PCSC_BT_START};
      encCls = BLK_S;
    end else begin
      for (int k = 0; k < 8; k++) begin
        if (txCtrl == (8'hff << k) && txData[8*k +: 8] == `PCSC_CH_TERM) begin
          lowBytes = txData & ((64'h1 << (8 * k)) - 64'h1);
          encPay = {lowBytes[55:0], termType(k)};
          encCls = BLK_T;
        end
      end
    end
  end

  always_comb begin
    txSeqNxt = txSeq_r;
    txSeqBad = (encCls == BLK_E);
    case (txSeq_r) // see [R2]
      SEQ_IDLE: begin
        if (encCls == BLK_S) begin
          txSeqNxt = SEQ_PKT;
        end else if (encCls == BLK_D || encCls == BLK_T) begin
          txSeqBad = 1'b1;
        end
      end
      SEQ_PKT: begin
        if (encCls == BLK_T || encCls == BLK_E) begin
          txSeqNxt = SEQ_IDLE;
        end else if (encCls == BLK_S || encCls == BLK_C) begin
          txSeqBad = 1'b1;
          txSeqNxt = SEQ_IDLE;
        end
      end
      default: txSeqNxt = SEQ_IDLE;
    endcase
  end

  // scrambler, disparity, slip
  logic [57:0] txScr_r, txScrNxt;
  logic [63:0] txPayChk, scrOut, txPayScr;
  logic signed [8:0] rd_r;
  int wd;
  logic inv;
  logic [66:0] txWord, txPrev_r, slipped;
  logic [133:0] cat;
  logic [6:0] txSlip_r;
  logic txSlipPrev_r, rxSlipPrev_r;

  assign txPayChk = txSeqBad ? {{8{`PCSC_E_CODE}}, `PCSC_BT_IDLE} : encPay;
  assign {txScrNxt, scrOut} = scram(txPayChk, txScr_r, ~scrSync, 1'b0); // see [R5] [R6] [R7]
  assign txPayScr = scrEn ? scrOut : txPayChk;
  assign wd = 2 * $countones(txPayScr) - 64;
  // inverting whenever word and running sum lean the same way bounds the sum to one word
  assign inv = dispOn && ((rd_r > 0 && wd > 0) || (rd_r < 0 && wd < 0)); // see [R10]
  assign txWord = {dispOn & inv, txPayScr ^ {64{inv}}, txSeqBad ? `PCSC_HDR_CTRL : encHdr} & cwMask; // see [R11]
  assign cat = ({67'h0, txWord} << cw) | {67'h0, txPrev_r};
  assign slipped = 67'(cat >> (cw - txSlip_r)) & cwMask; // see [R20]

  always_ff @(posedge clk) begin
    if (rst) begin
      txSeq_r <= SEQ_IDLE;
      txScr_r <= {`PCSC_SEED_HI, `PCSC_SEED_RESET};
      rd_r <= '0;
      txPrev_r <= '0;
      txSequenceError <= 1'b0;
    end else begin
      txSequenceError <= txFire & txSeqBad;
      if (seedLoad_r) begin
        txScr_r <= seedState;
      end else if (txFire && scrEn) begin
        txScr_r <= txScrNxt;
      end
      if (txFire) begin
        txSeq_r <= txSeqNxt;
        txPrev_r <= txWord;
        if (dispOn) begin
          rd_r <= 9'(int'(rd_r) + (inv ? -wd : wd));
        end
      end
    end
  end

  // slip edges on this clock
  always_ff @(posedge clk) begin
    if (rst) begin
      txSlipPrev_r <= 1'b0;
      rxSlipPrev_r <= 1'b0;
      txSlip_r <= '0;
    end else begin
      txSlipPrev_r <= transmitSlipPulse;
      rxSlipPrev_r <= receiveSlipPulse;
      if (!txSlipMode) begin
        txSlip_r <= '0;
      end else if (transmitSlipPulse && !txSlipPrev_r) begin
        txSlip_r <= (txSlip_r >= cw - 7'd1) ? 7'd0 : txSlip_r + 7'd1; // see [R23]
      end
    end
  end

  // transmit gearbox
  logic [AW-1:0] txAcc_r, txAccNxt;
  logic [7:0] txCnt_r, txCntAfter;
  logic txPop;
  assign txPop = txCnt_r >= 8'(PMA_W);
  assign txCntAfter = txPop ? txCnt_r - 8'(PMA_W) : txCnt_r;
  assign txReady = ({1'b0, txCntAfter} + {2'b0, cw}) <= 9'(AW);

  always_comb begin
    txAccNxt = txPop ? (txAcc_r >> PMA_W) : txAcc_r; // see [R17]
    if (txFire) begin
      txAccNxt = txAccNxt | ({{(AW-67){1'b0}}, slipped} << txCntAfter);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txAcc_r <= '0;
      txCnt_r <= '0;
      pmaTxData <= '0;
      pmaTxValid <= 1'b0;
    end else begin
      txAcc_r <= txAccNxt;
      txCnt_r <= txCntAfter + (txFire ? {1'b0, cw} : 8'd0);
      pmaTxValid <= txPop;
      if (txPop) begin
        pmaTxData <= txAcc_r[PMA_W-1:0] ^ {PMA_W{txPol}}; // see [R18]
      end
    end
  end

  // receive gearbox with one-bit slip ahead of the word pop
  logic [AW-1:0] rxAcc_r, rxAccNxt;
  logic [7:0] rxCnt_r, rxCntNxt;
  logic [66:0] rxWord_r, rxPopWord;
  logic rxWordV_r, rxPop, rxSlipReq, autoSlip_r;
  assign rxSlipReq = autoSlip_r | (rxSlipMode & receiveSlipPulse & ~rxSlipPrev_r); // see [R21] [R23]

  always_comb begin
    rxAccNxt = rxAcc_r;
    rxCntNxt = rxCnt_r;
    if (rxSlipReq && rxCnt_r != 8'd0) begin // see [R14]
      rxAccNxt = rxAccNxt >> 1;
      rxCntNxt = rxCntNxt - 8'd1;
    end
    rxPop = rxCntNxt >= {1'b0, cw};
    rxPopWord = rxAccNxt[66:0] & cwMask;
    if (rxPop) begin
      rxAccNxt = rxAccNxt >> cw;
      rxCntNxt = rxCntNxt - {1'b0, cw};
    end
    if (pmaRxValid) begin
      rxAccNxt = rxAccNxt | ({{(AW-PMA_W){1'b0}}, pmaRxData ^ {PMA_W{rxPol}}} << rxCntNxt); // see [R19]
      rxCntNxt = rxCntNxt + 8'(PMA_W);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxAcc_r <= '0;
      rxCnt_r <= '0;
      rxWord_r <= '0;
      rxWordV_r <= 1'b0;
    end else begin
      rxAcc_r <= rxAccNxt;
      rxCnt_r <= rxCntNxt;
      rxWordV_r <= rxPop;
      if (rxPop) begin
        rxWord_r <= rxPopWord;
      end
    end
  end

  // block synchronizer
  pcsc_sync_t syncSt_r;
  logic [6:0] goodCnt_r, hdrCnt_r;
  logic [4:0] badCnt_r;
  logic discard_r, hdrOk, judge, locked, badNow;
  assign hdrOk = rxWord_r[1] ^ rxWord_r[0];
  // the word popped while a slip is pending still has the old alignment
  assign judge = rxWordV_r & ~discard_r;
  assign locked = (syncSt_r == SYNC_LOCKED);
  assign badNow = judge & locked & ~hdrOk;
  assign blockAlignmentLocked = locked;

  always_ff @(posedge clk) begin
    if (rst) begin
      syncSt_r <= SYNC_SEARCH;
      goodCnt_r <= '0;
      hdrCnt_r <= '0;
      badCnt_r <= '0;
      autoSlip_r <= 1'b0;
      discard_r <= 1'b0;
      syncHeaderErrorFlag <= 1'b0;
    end else begin
      autoSlip_r <= 1'b0;
      syncHeaderErrorFlag <= badNow; // see [R16]
      if (rxWordV_r) begin
        discard_r <= 1'b0;
      end
      case (syncSt_r)
        SYNC_SEARCH: begin
          if (judge && hdrOk) begin
            if (goodCnt_r == `PCSC_LOCK_HDRS - 7'd1) begin // see [R15]
              syncSt_r <= SYNC_LOCKED;
              goodCnt_r <= '0;
              hdrCnt_r <= '0;
              badCnt_r <= '0;
            end else begin
              goodCnt_r <= goodCnt_r + 7'd1;
            end
          end else if (judge) begin
            goodCnt_r <= '0;
            autoSlip_r <= ~rxSlipMode; // see [R14] [R21]
            discard_r <= ~rxSlipMode;
          end
        end
        SYNC_LOCKED: begin
          if (judge) begin
            if (!hdrOk && badCnt_r == `PCSC_BAD_LOSE - 5'd1) begin // see [R24]
              syncSt_r <= SYNC_SEARCH;
              goodCnt_r <= '0;
              autoSlip_r <= ~rxSlipMode;
              discard_r <= ~rxSlipMode;
            end else if (hdrCnt_r == `PCSC_WIN_HDRS - 7'd1) begin
              hdrCnt_r <= '0;
              badCnt_r <= '0;
            end else begin
              hdrCnt_r <= hdrCnt_r + 7'd1;
              badCnt_r <= badCnt_r + (hdrOk ? 5'd0 : 5'd1);
            end
          end
        end
        default: syncSt_r <= SYNC_SEARCH;
      endcase
    end
  end

  // error-rate monitor
  logic [31:0] berTimer_r;
  logic [4:0] berCnt_r;
  logic winEnd, exceed;
  assign winEnd = berTimer_r == 32'(BER_WINDOW_CYC - 1);
  assign exceed = badNow && berCnt_r >= `PCSC_BER_LIMIT; // see [R22]

  always_ff @(posedge clk) begin
    if (rst || !locked) begin
      berTimer_r <= '0;
      berCnt_r <= '0;
      highErrorRateFlag <= 1'b0;
    end else begin
      berTimer_r <= winEnd ? 32'h0 : berTimer_r + 32'h1;
      if (winEnd) begin
        berCnt_r <= '0;
        highErrorRateFlag <= exceed;
      end else begin
        if (badNow && berCnt_r != 5'h1f) begin
          berCnt_r <= berCnt_r + 5'd1;
        end
        if (exceed) begin
          highErrorRateFlag <= 1'b1;
        end
      end
    end
  end

  // disparity check, descramble, decode
  logic [57:0] rxScr_r, rxScrNxt;
  logic [63:0] rxPayChk, dscOut, rxPay, rxPaySh, decData;
  logic [7:0] decCtrl;
  pcsc_blk_t decCls;
  pcsc_seq_t rxSeq_r;
  logic typeBad, rxErr;
  int lane;
  assign rxPayChk = rxWord_r[65:2] ^ {64{dispOn & rxWord_r[`PCSC_FLAG_BIT]}}; // see [R12]
  assign {rxScrNxt, dscOut} = scram(rxPayChk, rxScr_r, ~scrSync, 1'b1); // see [R8]
  assign rxPay = scrEn ? dscOut : rxPayChk;
  assign rxPaySh = rxPay >> 8;
  assign lane = termLane(rxPay[7:0]);

  always_comb begin
    decData = {8{`PCSC_CH_ERR}};
    decCtrl = 8'hff;
    decCls = BLK_E;
    typeBad = 1'b0;
    if (rxWord_r[1:0] == `PCSC_HDR_DATA) begin // see [R3]
      decData = rxPay;
      decCtrl = 8'h00;
      decCls = BLK_D;
    end else if (rxWord_r[1:0] == `PCSC_HDR_CTRL) begin
      if (rxPay[7:0] == `PCSC_BT_IDLE && rxPay[63:8] == 56'h0) begin
        decData = {8{`PCSC_CH_IDLE}};
        decCls = BLK_C;
      end else if (rxPay[7:0] == `PCSC_BT_START) begin
        decData = {rxPay[63:8], `PCSC_CH_START};
        decCtrl = 8'h01;
        decCls = BLK_S;
      end else if (lane < 8) begin
        decCtrl = 8'hff << lane;
        decCls = BLK_T;
        for (int j = 0; j < 8; j++) begin
          decData[8*j +: 8] = (j < lane) ? rxPaySh[8*j +: 8] : (j == lane) ? `PCSC_CH_TERM : `PCSC_CH_IDLE;
        end
      end else if (rxPay[7:0] != `PCSC_BT_IDLE) begin
        typeBad = 1'b1;
      end
    end
  end

  always_comb begin
    rxErr = highErrorRateFlag || decCls == BLK_E; // see [R4]
    case (rxSeq_r)
      SEQ_IDLE: rxErr = rxErr || decCls == BLK_D || decCls == BLK_T;
      SEQ_PKT: rxErr = rxErr || decCls == BLK_S || decCls == BLK_C;
      default: rxErr = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxScr_r <= {`PCSC_SEED_HI, `PCSC_SEED_RESET};
      rxSeq_r <= SEQ_IDLE;
      rxData <= '0;
      rxCtrl <= '0;
      rxValid <= 1'b0;
      descramblerErrorFlag <= 1'b0;
    end else begin
      if (seedLoad_r) begin
        rxScr_r <= seedState;
      end else if (rxWordV_r && scrEn) begin
        rxScr_r <= rxScrNxt;
      end
      rxValid <= judge & locked;
      descramblerErrorFlag <= judge & locked & typeBad;
      if (!locked) begin
        rxSeq_r <= SEQ_IDLE;
      end else if (judge) begin
        rxData <= rxErr ? {8{`PCSC_CH_ERR}} : decData;
        rxCtrl <= rxErr ? 8'hff : decCtrl;
        rxSeq_r <= (rxErr || decCls == BLK_T || decCls == BLK_C) ? SEQ_IDLE
                   : (decCls == BLK_S) ? SEQ_PKT : rxSeq_r;
      end
    end
  end

  // read side; header error count clears on read, a new error wins
  logic [15:0] errCnt_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      errCnt_r <= '0;
      regRdData <= '0;
    end else begin
      if (regRead && regAddr == `PCSC_REG_ERRS) begin
        errCnt_r <= badNow ? 16'h1 : 16'h0;
      end else if (badNow && errCnt_r != 16'hffff) begin
        errCnt_r <= errCnt_r + 16'h1;
      end
      regRdData <= '0;
      if (regRead) begin
        if (regAddr == `PCSC_REG_CTRL) begin
          regRdData <= {24'h0, ctrl_r};
        end else if (regAddr == `PCSC_REG_SEED) begin
          regRdData <= {17'h0, seed_r};
        end else if (regAddr == `PCSC_REG_STAT) begin
          regRdData <= {11'h0, berCnt_r, 1'b0, txSlip_r, 6'h0, highErrorRateFlag, locked};
        end else if (regAddr == `PCSC_REG_ERRS) begin
          regRdData <= {16'h0, errCnt_r};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### pcsc_top_props.sv
// port assertions for the coding and alignment block
`timescale 1ns/1ps
`default_nettype none
module pcsc_top_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire logic txValid,
  input wire logic txReady,
  input wire logic txSequenceError,
  input wire logic [63:0] rxData,
  input wire logic [7:0] rxCtrl,
  input wire logic rxValid,
  input wire logic blockAlignmentLocked,
  input wire logic syncHeaderErrorFlag,
  input wire logic highErrorRateFlag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence lockHeld;
    blockAlignmentLocked [*8];
  endsequence
  sequence berLow;
    !highErrorRateFlag [*4];
  endsequence
  chk_txerr_cause: assert property (txSequenceError |-> $past(txValid && txReady))
    else $error("sequence error without an accepted word");
  chk_sherr_locked: assert property (syncHeaderErrorFlag |-> $past(blockAlignmentLocked))
    else $error("header error while unlocked");
  chk_rx_locked: assert property (rxValid |-> blockAlignmentLocked || $past(blockAlignmentLocked))
    else $error("word delivered without lock");
  chk_ber_clear: assert property ($fell(blockAlignmentLocked) |-> ##1 berLow)
    else $error("high error flag kept after lock loss");
  chk_ber_locked: assert property ($rose(highErrorRateFlag) |-> $past(blockAlignmentLocked))
    else $error("high error flag raised without lock");
  chk_lock_hold: assert property ($rose(blockAlignmentLocked) |=> lockHeld)
    else $error("lock dropped right after it was gained");
  chk_err_word: assert property (rxValid && $past(highErrorRateFlag) && $past(highErrorRateFlag, 2)
    |-> rxData == {8{8'hfe}} && rxCtrl == 8'hff)
    else $error("normal word delivered while error rate high");
  chk_ready_reset: assert property ($past(rst) |-> txReady)
    else $error("gearbox not ready after reset");
endmodule
bind pcsc_top pcsc_top_props chk (.clk(clk), .rst(rst), .txValid(txValid), .txReady(txReady),
  .txSequenceError(txSequenceError), .rxData(rxData), .rxCtrl(rxCtrl), .rxValid(rxValid),
  .blockAlignmentLocked(blockAlignmentLocked), .syncHeaderErrorFlag(syncHeaderErrorFlag),
  .highErrorRateFlag(highErrorRateFlag));
`default_nettype wire

// ### pcsc_far_model.sv
// far-side model: serializer loopback that can corrupt words
`timescale 1ns/1ps
`default_nettype none
module pcsc_far_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // 0 clean, 1 two words in thirty-two zeroed, 2 every word zeroed
  input wire logic [1:0] garbleMode,
  // serializer words in both directions
  input wire logic [39:0] txWord,
  input wire logic txWordValid,
  output logic [39:0] rxWord,
  output logic rxWordValid
);
  logic [4:0] wordCnt_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      wordCnt_r <= 5'h00;
      rxWordValid <= 1'b0;
      rxWord <= 40'h0;
    end else begin
      rxWordValid <= txWordValid;
      if (txWordValid) begin
        wordCnt_r <= wordCnt_r + 5'h01;
        // eighty zero bits always cover one whole header and break it
        if (garbleMode == 2'h2 || (garbleMode == 2'h1 && wordCnt_r < 5'h02))
          rxWord <= 40'h0;
        else
          rxWord <= txWord;
      end else begin
        // held word inverted each cycle between words
        rxWord <= ~rxWord;
      end
    end
  end
endmodule
`default_nettype wire

// ### pcsc_top_tb_top.sv
// self-checking testbench of the coding and alignment block
`timescale 1ns/1ps
`default_nettype none
module pcsc_top_tb_top;
  localparam logic [63:0] IDLE = 64'h0707070707070707;
  localparam logic [63:0] START = 64'h00112233445566fb;
  localparam logic [63:0] DATA = 64'h0123456789abcdef;
  localparam logic [63:0] TERM = 64'h07070707070707fd;
  logic clk, rst, regWrite, regRead, txValid, txReady, txSequenceError, pmaTxValid, pmaRxValid;
  logic rxValid, transmitSlipPulse, blockAlignmentLocked, syncHeaderErrorFlag, highErrorRateFlag, receiveSlipPulse;
  logic [3:0] regAddr;
  logic [31:0] regWrData, regRdData, r;
  logic [63:0] txData, rxData, dataSeen;
  logic [7:0] txCtrl, rxCtrl;
  logic [39:0] pmaTxData, pmaRxData;
  logic [1:0] garbleMode;
  int bad_count, compares, shErrSeen, n;
  pcsc_top #(.PMA_W(40), .BER_WINDOW_CYC(1000)) dut (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .txData(txData),
    .txCtrl(txCtrl), .txValid(txValid), .txReady(txReady), .txSequenceError(txSequenceError),
    .pmaTxData(pmaTxData), .pmaTxValid(pmaTxValid), .pmaRxData(pmaRxData), .pmaRxValid(pmaRxValid),
    .rxData(rxData), .rxCtrl(rxCtrl), .rxValid(rxValid), .transmitSlipPulse(transmitSlipPulse),
    .receiveSlipPulse(receiveSlipPulse), .blockAlignmentLocked(blockAlignmentLocked),
    .syncHeaderErrorFlag(syncHeaderErrorFlag), .highErrorRateFlag(highErrorRateFlag),
    .descramblerErrorFlag());
  pcsc_far_model far (.clk(clk), .rst(rst), .garbleMode(garbleMode), .txWord(pmaTxData),
    .txWordValid(pmaTxValid), .rxWord(pmaRxData), .rxWordValid(pmaRxValid));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (syncHeaderErrorFlag === 1'b1) shErrSeen++;
    if (rxValid === 1'b1 && rxCtrl === 8'h00) dataSeen <= rxData;
  end
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic regWr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic regRd(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    r = regRdData;
  endtask
  function automatic logic sigOf(input int w);
    case (w)
      0: return blockAlignmentLocked;
      1: return highErrorRateFlag;
      2: return pmaTxValid;
      3: return txSequenceError;
      default: return rxValid;
    endcase
  endfunction
  task automatic waitSig(input int w, input logic lvl, input int lim, input string what);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (sigOf(w) !== lvl && k < lim);
    check(what, {63'h0, lvl}, {63'h0, sigOf(w)});
  endtask
  // called just after a clock edge; returns at the edge that takes the word
  task automatic sendWord(input logic [63:0] d, input logic [7:0] c);
    int k;
    k = 0;
    txData <= d;
    txCtrl <= c;
    do begin
      @(negedge clk);
      k++;
    end while (txReady !== 1'b1 && k < 50);
    check("word accepted", 64'h1, {63'h0, txReady});
    @(posedge clk);
  endtask
  task automatic results;
    $display("checks %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(25 * 40000);
    bad_count++;
    $display("watchdog expired");
    results;
  end
  initial begin
    rst = 1'b1;
    {regAddr, regWrData, regWrite, regRead, txValid, transmitSlipPulse, garbleMode, receiveSlipPulse} = '0;
    txData = IDLE;
    txCtrl = 8'hff;
    dataSeen = 64'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    regRd(4'h0);
    check("control reset", 64'h1, {32'h0, r});
    regRd(4'h4);
    check("seed reset", 64'h1, {32'h0, r});
    regWr(4'h4, 32'h00005a5a);
    regRd(4'h4);
    check("seed", 64'h5a5a, {32'h0, r});
    regRd(4'h2);
    check("unmapped", 64'h0, {32'h0, r});
    $display("test registers done");
    regWr(4'h0, 32'h00000008);
    @(posedge clk);
    txValid <= 1'b1;
    waitSig(2, 1'b1, 20, "first serial word");
    check("inverted idle bits", {24'h0, ~40'h79}, {24'h0, pmaTxData});
    $display("test transmit coding done");
    regWr(4'h0, 32'h00000039);
    repeat (3) begin
      @(posedge clk);
      transmitSlipPulse <= 1'b1;
      @(posedge clk);
      transmitSlipPulse <= 1'b0;
    end
    regRd(4'h8);
    check("tx slip count", 64'h3, {57'h0, r[14:8]});
    waitSig(0, 1'b1, 4000, "lock");
    @(posedge clk);
    sendWord(START, 8'h01);
    sendWord(DATA, 8'h00);
    sendWord(TERM, 8'hff);
    txData <= IDLE;
    n = 0;
    while (dataSeen !== DATA && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("decoded data", DATA, dataSeen);
    @(posedge clk);
    sendWord(DATA, 8'h00);
    txData <= IDLE;
    txCtrl <= 8'hff;
    waitSig(3, 1'b1, 5, "sequence error");
    $display("test packet done");
    garbleMode <= 2'h1;
    waitSig(1, 1'b1, 3000, "high error rate");
    check("lock kept", 64'h1, {63'h0, blockAlignmentLocked});
    check("header error pulses", 64'h1, {63'h0, shErrSeen != 0});
    regRd(4'hc);
    check("bad header count", 64'h1, {63'h0, r != 0});
    waitSig(4, 1'b1, 20, "error word");
    check("error word data", {8{8'hfe}}, rxData);
    check("error word ctrl", 64'hff, {56'h0, rxCtrl});
    $display("test error rate done");
    garbleMode <= 2'h2;
    waitSig(0, 1'b0, 1000, "lock lost");
    @(negedge clk);
    check("high error cleared", 64'h0, {63'h0, highErrorRateFlag});
    regWr(4'h0, 32'h00000087);
    garbleMode <= 2'h0;
    waitSig(0, 1'b1, 6000, "lock on 67-bit words");
    regRd(4'h8);
    check("status lock", 64'h1, {63'h0, r[0]});
    regWr(4'h0, 32'h000000c7);
    receiveSlipPulse <= 1'b1;
    waitSig(0, 1'b0, 1000, "lock lost by receive slip");
    $display("test relock done");
    results;
  end
endmodule
`default_nettype wire
